// ---- src/adcr_pkg.sv ----
// package: register map, field layout and timing constants of the converter
package adcr_pkg;
    // register word addresses on the bus (byte addresses)
    localparam logic [7:0] ADDR_RES_HIGH = 8'h00;
    localparam logic [7:0] ADDR_RES_LOW  = 8'h04;
    localparam logic [7:0] ADDR_CTRL0    = 8'h08;
    localparam logic [7:0] ADDR_CTRL1    = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_PIN_SEL  = 8'h18;
    // control 0 fields
    localparam int CTRL0_START_BIT   = 7;
    localparam int CTRL0_BUSY_BIT    = 6;
    localparam int CTRL0_ENABLE_BIT  = 5;
    localparam int CTRL0_JUSTIFY_BIT = 4;
    localparam int CTRL0_CHAN_LSB    = 0;
    // control 1 fields
    localparam int CTRL1_SRC_LSB     = 5;
    localparam int CTRL1_REF_LSB     = 3;
    localparam int CTRL1_CLK_LSB     = 0;
    // reset values
    localparam logic [7:0] CTRL0_RESET   = 8'h00;
    localparam logic [7:0] CTRL1_RESET   = 8'h00;
    localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
    localparam logic [3:0] PIN_SEL_RESET = 4'h0;
    // interrupt status bit
    localparam int IRQ_DONE_BIT = 0;
    // converter timing: converter clock periods per conversion
    localparam logic [4:0] CONV_CLOCKS = 5'h10;
    // source, reference and channel select codes
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_AMP0    = 3'h2;
    localparam logic [2:0] SRC_AMP1    = 3'h3;
    localparam logic [2:0] SRC_LINE    = 3'h4;
    localparam logic [1:0] REF_SUPPLY  = 2'h1;
    localparam logic [3:0] CHAN_LAST   = 4'h3;
    localparam int RESULT_W = 12;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_CONV  = 2'b10
    } adcr_state_t;
endpackage

// ---- src/adcr_top.sv ----
// converter control and result registers behind an APB slave
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module adcr_top
    import adcr_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        SYS_RST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [7:0]  PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic [11:0] CONV_DATA_I,
    output logic             CONV_POWER_O,
    output logic             CONV_SAMPLE_O,
    output logic             CONV_CLK_EN_O,
    output logic      [3:0]  EXT_CHAN_SEL_O,
    output logic      [4:0]  INT_SRC_SEL_O,
    output logic             REF_SUPPLY_O,
    output logic      [3:0]  PIN_ANALOG_O,
    output logic      [3:0]  PIN_PULLUP_EN_O,
    input  wire logic [3:0]  PIN_PULLUP_REQ_I,
    output logic             IRQ_O
);
    // register state
    logic [7:0]  ctrl0_q, ctrl0_d;
    logic [7:0]  ctrl1_q, ctrl1_d;
    logic [7:0]  mask_q, mask_d;
    logic [7:0]  stat_q, stat_d;
    logic [3:0]  pin_q, pin_d;
    logic [11:0] result_q, result_d;
    logic [6:0]  div_q, div_d;
    logic [4:0]  cnt_q, cnt_d;
    logic [11:0] data_s1_q, data_s2_q;
    adcr_state_t state_q, state_d;
    logic        done_q, done_d;

    logic        wr_en, rd_en, addr_ok, tick, enable, start_w;
    logic [7:0]  rd_byte, res_high, res_low;
    logic [6:0]  div_mask;

    // bus access decode, zero wait states
    assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_en     = PSEL_I && PENABLE_I && !PWRITE_I;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
    assign enable    = ctrl0_q[CTRL0_ENABLE_BIT];
    assign start_w   = PWDATA_I[CTRL0_START_BIT];

    // converter data pins from the analog domain, two-stage synchroniser
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            data_s1_q <= 12'h000;
            data_s2_q <= 12'h000;
        end else begin
            data_s1_q <= CONV_DATA_I;
            data_s2_q <= data_s1_q;
        end
    end

    // result formatting by justification
    always_comb begin
        if (!ctrl0_q[CTRL0_JUSTIFY_BIT]) begin
            res_high = result_q[11:4];
            res_low  = {result_q[3:0], 4'h0};
        end else begin
            res_high = {4'h0, result_q[11:8]};
            res_low  = result_q[7:0];
        end
    end

    // read multiplexer, busy shown live from the sequencer
    always_comb begin
        addr_ok = 1'b1;
        rd_byte = 8'h00;
        unique case (PADDR_I)
            ADDR_RES_HIGH: rd_byte = res_high;
            ADDR_RES_LOW:  rd_byte = res_low;
            ADDR_CTRL0:    rd_byte = ctrl0_q;
            ADDR_CTRL1:    rd_byte = ctrl1_q;
            ADDR_IRQ_STAT: rd_byte = stat_q;
            ADDR_IRQ_MASK: rd_byte = mask_q;
            ADDR_PIN_SEL:  rd_byte = {4'h0, pin_q};
            default:       addr_ok = 1'b0;
        endcase
    end

    // read data register
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            PRDATA_O <= {24'h00_0000, rd_byte};
        end
    end

    // clock divider: tick every 2**code system cycles
    always_comb begin
        div_mask = 7'h7F >> (3'd7 - ctrl1_q[2:0]);
        div_d    = enable ? div_q + 7'h01 : 7'h00;
        tick     = enable && ((div_q & div_mask) == 7'h00);
    end

    // software register writes and the conversion sequencer
    always_comb begin
        ctrl0_d  = ctrl0_q;
        ctrl1_d  = ctrl1_q;
        mask_d   = mask_q;
        pin_d    = pin_q;
        stat_d   = stat_q;
        state_d  = state_q;
        cnt_d    = cnt_q;
        result_d = result_q;
        done_d   = 1'b0;
        if (wr_en) begin
            unique case (PADDR_I)
                ADDR_CTRL0: begin
                    ctrl0_d = PWDATA_I[7:0];
                    ctrl0_d[CTRL0_BUSY_BIT] = ctrl0_q[CTRL0_BUSY_BIT];
                end
                ADDR_CTRL1:    ctrl1_d = PWDATA_I[7:0];
                ADDR_IRQ_MASK: mask_d  = PWDATA_I[7:0];
                ADDR_PIN_SEL:  pin_d   = PWDATA_I[3:0];
                ADDR_IRQ_STAT: stat_d  = stat_q & ~PWDATA_I[7:0];
                default: ;
            endcase
        end
        unique case (state_q)
            ST_IDLE: begin
                // high half of the start sequence
                if (wr_en && PADDR_I == ADDR_CTRL0 && start_w && enable)
                    state_d = ST_ARMED;
            end
            ST_ARMED: begin
                // low half launches the conversion
                if (!enable) begin
                    state_d = ST_IDLE;
                end else if (wr_en && PADDR_I == ADDR_CTRL0 && !start_w) begin
                    state_d = ST_CONV;
                    cnt_d   = CONV_CLOCKS;
                    ctrl0_d[CTRL0_BUSY_BIT] = 1'b1;
                end
            end
            ST_CONV: begin
                if (!enable) begin
                    state_d = ST_IDLE;
                    ctrl0_d[CTRL0_BUSY_BIT] = 1'b0;
                end else if (tick) begin
                    cnt_d = cnt_q - 5'h01;
                    if (cnt_q == 5'h01) begin
                        state_d  = ST_IDLE;
                        result_d = data_s2_q;
                        ctrl0_d[CTRL0_BUSY_BIT] = 1'b0;
                        done_d   = 1'b1;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // hardware set wins over a software clear
        if (done_d)
            stat_d[IRQ_DONE_BIT] = 1'b1;
    end

    // register update
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ctrl0_q  <= CTRL0_RESET;
            ctrl1_q  <= CTRL1_RESET;
            mask_q   <= IRQ_MASK_RESET;
            stat_q   <= 8'h00;
            pin_q    <= PIN_SEL_RESET;
            result_q <= 12'h000;
            div_q    <= 7'h00;
            cnt_q    <= 5'h00;
            state_q  <= ST_IDLE;
            done_q   <= 1'b0;
        end else begin
            ctrl0_q  <= ctrl0_d;
            ctrl1_q  <= ctrl1_d;
            mask_q   <= mask_d;
            stat_q   <= stat_d;
            pin_q    <= pin_d;
            result_q <= result_d;
            div_q    <= div_d;
            cnt_q    <= cnt_d;
            state_q  <= state_d;
            done_q   <= done_d;
        end
    end

    // analog side controls
    always_comb begin
        INT_SRC_SEL_O = 5'h00;
        unique case (ctrl1_q[7:5])
            SRC_BANDGAP: INT_SRC_SEL_O = 5'h02;
            SRC_AMP0:    INT_SRC_SEL_O = 5'h04;
            SRC_AMP1:    INT_SRC_SEL_O = 5'h08;
            SRC_LINE:    INT_SRC_SEL_O = 5'h10;
            default:     INT_SRC_SEL_O = 5'h01;          // external path
        endcase
    end

    // channel decode: codes above the last leave the input floating
    always_comb begin
        EXT_CHAN_SEL_O = 4'h0;
        if (ctrl0_q[3:0] <= CHAN_LAST)
            EXT_CHAN_SEL_O = 4'h1 << ctrl0_q[1:0];
    end

    assign CONV_POWER_O    = enable;
    assign CONV_SAMPLE_O   = (state_q == ST_CONV);
    assign CONV_CLK_EN_O   = tick;
    assign REF_SUPPLY_O    = (ctrl1_q[4:3] == REF_SUPPLY);
    assign PIN_ANALOG_O    = pin_q;
    assign PIN_PULLUP_EN_O = PIN_PULLUP_REQ_I & ~pin_q;
    assign IRQ_O           = |(stat_q & mask_q);

    // checks: each property names its own clock and reset
    // high half of the start pair, then the armed state
    sequence s_start_pair;
        wr_en && PADDR_I == ADDR_CTRL0 && start_w && enable
        ##1 (state_q == ST_ARMED);
    endsequence

    // low half of the start pair while armed and powered
    sequence s_launch;
        state_q == ST_ARMED && enable && wr_en
        && PADDR_I == ADDR_CTRL0 && !start_w;
    endsequence

    // last converter clock tick of a running conversion
    sequence s_finish;
        state_q == ST_CONV && enable && tick && cnt_q == 5'h01;
    endsequence

    // launch sets busy and starts sampling
    property p_start_busy;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_launch |=> ctrl0_q[CTRL0_BUSY_BIT] && state_q == ST_CONV;
    endproperty
    AST_START_BUSY: assert property (p_start_busy)
        else $error("busy not set after start sequence");

    // arming alone must not raise busy
    property p_arm;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_start_pair |-> !ctrl0_q[CTRL0_BUSY_BIT];
    endproperty
    AST_ARM: assert property (p_arm)
        else $error("busy set before start released");

    // completion flag stands once busy falls while powered
    property p_done_irq;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        $fell(ctrl0_q[CTRL0_BUSY_BIT]) && enable |-> stat_q[IRQ_DONE_BIT];
    endproperty
    AST_DONE_IRQ: assert property (p_done_irq)
        else $error("done flag missing");

    // last tick: busy clears, done flag and done pulse land together
    property p_finish;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        s_finish |=> !ctrl0_q[CTRL0_BUSY_BIT]
                     && stat_q[IRQ_DONE_BIT] && done_q;
    endproperty
    AST_FINISH: assert property (p_finish)
        else $error("busy or done flag wrong at completion");

    // result register holds the sample of the completion cycle
    property p_result;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        done_q |-> result_q == $past(data_s2_q);
    endproperty
    AST_RESULT: assert property (p_result)
        else $error("result not loaded at completion");

    // no result update without power
    property p_hold;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !$past(enable) |-> $stable(result_q);
    endproperty
    AST_HOLD: assert property (p_hold)
        else $error("result changed while disabled");

    // unused bit positions of the result bytes read zero
    property p_just;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        ctrl0_q[CTRL0_JUSTIFY_BIT] |-> res_high[7:4] == 4'h0;
    endproperty
    AST_JUST: assert property (p_just)
        else $error("unused high bits nonzero");
    property p_just0;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !ctrl0_q[CTRL0_JUSTIFY_BIT] |-> res_low[3:0] == 4'h0;
    endproperty
    AST_JUST0: assert property (p_just0)
        else $error("unused low bits nonzero");

    // unmasked completion raises the interrupt line
    property p_irq;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        done_q && mask_q[IRQ_DONE_BIT] |-> IRQ_O;
    endproperty
    AST_IRQ: assert property (p_irq)
        else $error("irq missing after unmasked completion");

    // sequencer returns to idle once power is removed
    property p_off;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        !enable |=> state_q == ST_IDLE;
    endproperty
    AST_OFF: assert property (p_off)
        else $error("sequencer runs while off");

    // software writes in idle never raise the read-only busy flag
    property p_busy_ro;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        wr_en && PADDR_I == ADDR_CTRL0 && state_q == ST_IDLE
        |=> !ctrl0_q[CTRL0_BUSY_BIT];
    endproperty
    AST_BUSY_RO: assert property (p_busy_ro)
        else $error("busy written by software");

    // floating channel codes select no external pin
    property p_float;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        ctrl0_q[3:0] > CHAN_LAST |-> EXT_CHAN_SEL_O == 4'h0;
    endproperty
    AST_FLOAT: assert property (p_float)
        else $error("floating code drives a pin select");

    // analog pins lose their pull-up
    property p_pullup;
        @(posedge CLK_I) disable iff (SYS_RST_I)
        (PIN_PULLUP_EN_O & pin_q) == 4'h0;
    endproperty
    AST_PULLUP: assert property (p_pullup)
        else $error("pull-up left on an analog pin");

endmodule // adcr_top

// ---- test/adcr_core_model.sv ----
// analog core model: tags each sample with the routed input
`timescale 1ns/1ns
module adcr_core_model (
    input  wire logic        clk_i,
    input  wire logic        power_i,
    input  wire logic        sample_i,
    input  wire logic [3:0]  chan_sel_i,
    input  wire logic [4:0]  src_sel_i,
    output logic      [11:0] data_o
);
    initial data_o = 12'h5A5;
    // routed input while sampling, a toggling pattern otherwise
    always @(posedge clk_i) begin
        if (power_i && sample_i) begin
            data_o <= {1'b1, chan_sel_i, src_sel_i, 2'b01};
        end else begin
            data_o <= ~data_o;
        end
    end
endmodule // adcr_core_model

// ---- test/adc_control_registers_bench.sv ----
// self-checking bench for the converter control registers
`timescale 1ns/1ns
module adc_control_registers_bench;
    import adcr_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pull_req = 4'hF;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, power, sample, clk_en, ref_sup, irq;
    logic [11:0] conv_data;
    logic [3:0]  chan_sel, pin_an, pull_en;
    logic [4:0]  src_sel;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #5 clk = ~clk;
    // cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    adcr_top dut_u (.CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .CONV_DATA_I(conv_data), .CONV_POWER_O(power),
        .CONV_SAMPLE_O(sample), .CONV_CLK_EN_O(clk_en),
        .EXT_CHAN_SEL_O(chan_sel), .INT_SRC_SEL_O(src_sel),
        .REF_SUPPLY_O(ref_sup), .PIN_ANALOG_O(pin_an),
        .PIN_PULLUP_EN_O(pull_en), .PIN_PULLUP_REQ_I(pull_req), .IRQ_O(irq));
    adcr_core_model model_u (.clk_i(clk), .power_i(power),
        .sample_i(sample), .chan_sel_i(chan_sel), .src_sel_i(src_sel),
        .data_o(conv_data));

    task automatic check(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait-state count assumed: the bench timeout ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [11:0] exp_data(input logic [3:0] ch,
                                             input logic [2:0] s);
        logic [4:0] so;
        so = (s >= 3'h1 && s <= 3'h4) ? 5'h01 << s : 5'h01;
        return {1'b1, (ch <= 4'h3) ? 4'h1 << ch : 4'h0, so, 2'b01};
    endfunction
    // start, poll busy, then read both result bytes
    task automatic convert(input logic j, input logic [3:0] ch,
                           input logic [2:0] s);
        logic [11:0] e;
        int n;
        e = exp_data(ch, s);
        n = 0;
        apb(1'b1, ADDR_CTRL1, {24'h0, s, 5'h01});
        // power first: a start high only arms an enabled converter
        apb(1'b1, ADDR_CTRL0, {24'h0, 2'b00, 1'b1, j, ch});
        apb(1'b1, ADDR_CTRL0, {24'h0, 2'b10, 1'b1, j, ch});
        apb(1'b1, ADDR_CTRL0, {24'h0, 2'b00, 1'b1, j, ch});
        apb(1'b0, ADDR_CTRL0, 32'h0);
        check("busy set", {31'h0, rd[6]}, 32'h1);
        check("sampling", {31'h0, sample}, 32'h1);
        do begin
            apb(1'b0, ADDR_CTRL0, 32'h0);
            n++;
        end while (rd[6] && n < 100);
        check("busy clear", {31'h0, rd[6]}, 32'h0);
        check("sample off", {31'h0, sample}, 32'h0);
        apb(1'b0, ADDR_RES_HIGH, 32'h0);
        check("high", rd, j ? {28'h0, e[11:8]} : {24'h0, e[11:4]});
        apb(1'b0, ADDR_RES_LOW, 32'h0);
        check("low", rd, j ? {24'h0, e[7:0]} : {24'h0, e[3:0], 4'h0});
        apb(1'b0, ADDR_IRQ_STAT, 32'h0);
        check("done flag", rd, 32'h1);
    endtask

    task automatic t_reset();
        check("irq rst", {31'h0, irq}, 32'h0);
        check("src rst", {27'h0, src_sel}, 32'h1);
        check("sample rst", {31'h0, sample}, 32'h0);
        check("pullup rst", {28'h0, pull_en}, 32'hF);
        apb(1'b0, ADDR_CTRL0, 32'h0);
        check("ctrl0 rst", rd, 32'h0);
        apb(1'b0, ADDR_CTRL1, 32'h0);
        check("ctrl1 rst", rd, 32'h0);
        check("chan rst", {28'h0, chan_sel}, 32'h1);
        check("power rst", {31'h0, power}, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped data", rd, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_conv();
        logic [11:0] e;
        e = exp_data(4'h3, 3'h5);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        convert(1'b0, 4'h2, 3'h0);
        check("irq on", {31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        #1 check("irq off", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0);
        // internal source with a floating channel
        convert(1'b1, 4'h7, 3'h1);
        check("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        convert(1'b1, 4'h3, 3'h5);
        // disabled: the start arms for one cycle on the old enable, launches nothing, results held
        apb(1'b1, ADDR_CTRL0, 32'h90);
        apb(1'b1, ADDR_CTRL0, 32'h10);
        #1 check("power off", {31'h0, power}, 32'h0);
        apb(1'b0, ADDR_RES_LOW, 32'h0);
        check("held", rd, {24'h0, e[7:0]});
        // power removed mid-conversion: abort, busy clears, result kept
        apb(1'b1, ADDR_CTRL0, 32'h20);
        apb(1'b1, ADDR_CTRL0, 32'hA0);
        apb(1'b1, ADDR_CTRL0, 32'h20);
        apb(1'b1, ADDR_CTRL0, 32'h00);
        apb(1'b0, ADDR_CTRL0, 32'h0);
        check("abort busy", rd, 32'h0);
        apb(1'b0, ADDR_RES_HIGH, 32'h0);
        check("abort held", rd, {24'h0, e[11:4]});
        $display("test conversion done");
    endtask
    task automatic t_route();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, ADDR_CTRL0, {28'h0, 4'(i)});
            #1 check("chan", {28'h0, chan_sel},
                  (i < 4) ? 32'h1 << i : 32'h0);
        end
        // each source code paired with reference code i[1:0]; only reference code 1 selects the supply
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, ADDR_CTRL1, {24'h0, 3'(i), 2'(i), 3'h0});
            #1 check("src", {27'h0, src_sel},
                  (i >= 1 && i <= 4) ? 32'h1 << i : 32'h1);
            check("ref", {31'h0, ref_sup}, {31'h0, 2'(i) == 2'h1});
        end
        apb(1'b1, ADDR_PIN_SEL, 32'h5);
        #1 check("pullup", {28'h0, pull_en}, 32'hA);
        check("analog pins", {28'h0, pin_an}, 32'h5);
        $display("test routing done");
    endtask
    task automatic t_div();
        int n;
        apb(1'b1, ADDR_CTRL0, 32'h20);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, ADDR_CTRL1, {29'h0, 3'(c)});
            n = 0;
            // sampled mid-cycle, clear of the launching edge
            do begin
                @(negedge clk);
                n++;
            end while (clk_en !== 1'b1 && n < 300);
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (clk_en !== 1'b1 && n < 300);
            check("tick gap", n, 32'h1 << c);
        end
        $display("test divider done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_conv();
        t_route();
        t_div();
        test_done();
    end
endmodule // adc_control_registers_bench
